// ---- shared/cms_pkg.sv ----
package cms_pkg;
  // clock
  localparam int CLK_PERIOD_NS = 5;
  // timing: start-up window, transmit half-bit, receive gap that ends a frame
  localparam int PHASE1_TIME_US = 50000;
  localparam int PHASE1_CYCLES = PHASE1_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int TX_HALF_BIT_NS = 1000;
  localparam int TX_HALF_CYCLES = (TX_HALF_BIT_NS / CLK_PERIOD_NS) < 1 ? 1 : TX_HALF_BIT_NS / CLK_PERIOD_NS;
  localparam int FRAME_GAP_NS = 400;
  localparam int FRAME_GAP_CYCLES = (FRAME_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // frame lengths and fixed values
  localparam int KEY_BITS = 16;
  localparam int CMD_BITS = 14;
  localparam int TX_BITS = 18;
  localparam logic [15:0] ENTRY_KEY = 16'h5A5A;
  localparam logic [1:0] TX_START = 2'h1;
  localparam logic [2:0] SV_OK = 3'h5;
  localparam logic [2:0] SV_ERR = 3'h6;
  localparam logic [3:0] EXIT_ADDR = 4'hA;
  localparam logic [7:0] EXIT_DATA = 8'h80;
  localparam logic [3:0] THIRD_CONFIG_REGISTER_ADDR = 4'h2;
  localparam int LOCK_BIT = 0;
  // command frame fields
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_RW_BIT = 12;
  localparam int CMD_PAR_BIT = 13;
  // transmit word fields
  localparam int TX_SV_LSB = 0;
  localparam int TX_DATA_LSB = 3;
  localparam int TX_ADDR_LSB = 11;
  localparam int TX_PAR_BIT = 15;
  // register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PULSE_ONE = 8'h04;
  localparam logic [7:0] REG_PULSE_MIN = 8'h08;
  localparam logic [7:0] REG_PULSE_MAX = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_CFG_BASE = 8'h40;
  localparam int CTRL_SYNC_MODE = 0;
  localparam int ST_PHASE1 = 0;
  localparam int ST_CONFIG = 1;
  localparam int ST_TX_BUSY = 2;
  localparam int ST_LOCKED = 3;
  localparam int ST_BAD_PULSE = 4;
  localparam logic [7:0] PULSE_ONE_RST = 8'h0C;
  localparam logic [7:0] PULSE_MIN_RST = 8'h02;
  localparam logic [7:0] PULSE_MAX_RST = 8'h30;
endpackage

// ---- rtl/cms_pulse_rx.sv ----
`timescale 1ns/1ps
module cms_pulse_rx #(
  parameter int GAP_CYCLES = cms_pkg::FRAME_GAP_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // supply-line pulse level, asynchronous
  input wire logic line_raw,
  // duration thresholds in clock cycles
  input wire logic [7:0] pulse_one,
  input wire logic [7:0] pulse_min,
  input wire logic [7:0] pulse_max,
  // decoded events
  output logic rise,
  output logic bit_strobe,
  output logic bit_val,
  output logic bad_pulse,
  output logic frame_end
);
  logic sync_a;
  logic sync_b;
  logic prev;
  logic [7:0] hi_len;
  logic [7:0] lo_len;
  logic in_frame;
  logic fall;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync_a <= line_raw;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end

  assign rise = sync_b & ~prev;
  assign fall = ~sync_b & prev;

  // pulse width saturates so an overlong high pulse is still judged too long when it falls
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hi_len <= 8'h00;
      lo_len <= 8'h00;
    end else begin
      hi_len <= rise ? 8'h01 : (sync_b && hi_len != 8'hFF) ? hi_len + 8'h01 : hi_len;
      lo_len <= fall ? 8'h01 : (!sync_b && lo_len != 8'hFF) ? lo_len + 8'h01 : lo_len;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bit_strobe <= 1'b0;
      bit_val <= 1'b0;
      bad_pulse <= 1'b0;
    end else begin
      bit_strobe <= fall && hi_len >= pulse_min && hi_len <= pulse_max;
      bad_pulse <= fall && (hi_len < pulse_min || hi_len > pulse_max);
      bit_val <= hi_len >= pulse_one;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      in_frame <= 1'b0;
      frame_end <= 1'b0;
    end else begin
      frame_end <= in_frame && !sync_b && 32'(lo_len) == GAP_CYCLES;
      if (rise) begin
        in_frame <= 1'b1;
      end else if (!sync_b && 32'(lo_len) == GAP_CYCLES) begin
        in_frame <= 1'b0;
      end
    end
  end
endmodule

// ---- rtl/cms_manchester_tx.sv ----
`timescale 1ns/1ps
module cms_manchester_tx #(
  parameter int HALF_CYCLES = cms_pkg::TX_HALF_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // frame request
  input wire logic start,
  input wire logic [cms_pkg::TX_BITS-1:0] frame,
  output logic busy,
  // current-mode line, high draws the signalling current
  output logic cur_on
);
  logic [15:0] div;
  logic half_tick;
  logic [cms_pkg::TX_BITS-1:0] sh;
  logic [4:0] left;
  logic second;

  assign half_tick = busy && 32'(div) == HALF_CYCLES - 1;

  always_ff @(posedge sys_clk) begin
    if (!rstn || !busy || half_tick) begin
      div <= 16'h0000;
    end else begin
      div <= div + 16'h0001;
    end
  end

  // manchester-1: a one is high then low, a zero low then high
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      busy <= 1'b0;
      sh <= '0;
      left <= 5'h00;
      second <= 1'b0;
      cur_on <= 1'b0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      sh <= frame;
      left <= 5'(cms_pkg::TX_BITS);
      second <= 1'b0;
      cur_on <= frame[0];
    end else if (half_tick) begin
      if (!second) begin
        second <= 1'b1;
        cur_on <= ~sh[0];
      end else if (left == 5'h01) begin
        busy <= 1'b0;
        cur_on <= 1'b0;
      end else begin
        second <= 1'b0;
        left <= left - 5'h01;
        sh <= sh >> 1;
        cur_on <= sh[1];
      end
    end
  end
endmodule

// ---- rtl/cms_config_port.sv ----
`timescale 1ns/1ps
module cms_config_port #(
  parameter int PHASE1_CYCLES = cms_pkg::PHASE1_CYCLES,
  parameter int TX_HALF_CYCLES = cms_pkg::TX_HALF_CYCLES,
  parameter int GAP_CYCLES = cms_pkg::FRAME_GAP_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // bus link
  input wire logic bus_supply_positive,
  output logic cur_tx_on,
  // fuse state
  input wire logic otp_lock_flag,
  // mode outputs to the rest of the device
  output logic config_mode,
  output logic autozero_off,
  output logic sync_tx_disable,
  output logic sync_pulse
);
  typedef enum {CMS_PHASE1, CMS_NORMAL, CMS_CFG_IDLE, CMS_CFG_TX, CMS_EXIT_TX} cms_state_e;

  cms_state_e state;
  cms_state_e next_state;
  logic [31:0] phase1_cnt;
  logic ctrl_sync_mode;
  logic [7:0] pulse_one;
  logic [7:0] pulse_min;
  logic [7:0] pulse_max;
  logic bad_seen;
  logic bus_ack;
  logic [7:0] cfg_ram [16];
  logic [15:0] rx_sh;
  logic [4:0] rx_cnt;
  logic frame_bad;
  logic rx_rise;
  logic rx_bit;
  logic rx_val;
  logic rx_bad;
  logic rx_end;
  logic tx_start;
  logic tx_go;
  logic tx_busy;
  logic [cms_pkg::TX_BITS-1:0] tx_frame;
  logic [cms_pkg::TX_BITS-1:0] next_frame;
  logic key_ok;
  logic cmd_ok;
  logic [13:0] cmd;
  logic [7:0] cmd_data;
  logic [3:0] cmd_addr;
  logic cmd_read;
  logic cmd_par_ok;
  logic cmd_exit;
  logic do_store;

  // register view of the configuration space; the lock flag always shows the fuse state
  function automatic logic [7:0] cfg_value(input logic [3:0] a, input logic [7:0] raw, input logic lock);
    logic [7:0] v;
    v = raw;
    if (a == cms_pkg::THIRD_CONFIG_REGISTER_ADDR) begin
      v[cms_pkg::LOCK_BIT] = lock;
    end
    return v;
  endfunction

  // one fixed answer format, independent of any configuration setting
  function automatic logic [cms_pkg::TX_BITS-1:0] build_frame(
    input logic [3:0] a, input logic [7:0] d, input logic [2:0] sv);
    logic [15:0] w;
    w = 16'h0000;
    w[cms_pkg::TX_SV_LSB +: 3] = sv;
    w[cms_pkg::TX_DATA_LSB +: 8] = d;
    w[cms_pkg::TX_ADDR_LSB +: 4] = a;
    w[cms_pkg::TX_PAR_BIT] = ^w[14:0];
    return {w, cms_pkg::TX_START};
  endfunction

  cms_pulse_rx #(
    .GAP_CYCLES(GAP_CYCLES)
  ) u_rx (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .line_raw(bus_supply_positive),
    .pulse_one(pulse_one),
    .pulse_min(pulse_min),
    .pulse_max(pulse_max),
    .rise(rx_rise),
    .bit_strobe(rx_bit),
    .bit_val(rx_val),
    .bad_pulse(rx_bad),
    .frame_end(rx_end)
  );

  cms_manchester_tx #(
    .HALF_CYCLES(TX_HALF_CYCLES)
  ) u_tx (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(tx_go),
    .frame(tx_frame),
    .busy(tx_busy),
    .cur_on(cur_tx_on)
  );

  // frame assembly, bits arrive lsb first and enter at the top
  always_ff @(posedge sys_clk) begin
    if (!rstn || rx_end) begin
      rx_sh <= 16'h0000;
      rx_cnt <= 5'h00;
      frame_bad <= 1'b0;
    end else begin
      if (rx_bit) begin
        rx_sh <= {rx_val, rx_sh[15:1]};
        rx_cnt <= (rx_cnt == 5'h1F) ? rx_cnt : rx_cnt + 5'h01;
      end
      if (rx_bad) begin
        frame_bad <= 1'b1;
      end
    end
  end

  assign key_ok = rx_end && !frame_bad && rx_cnt == 5'(cms_pkg::KEY_BITS)
                  && rx_sh == cms_pkg::ENTRY_KEY;
  assign cmd_ok = rx_end && !frame_bad && rx_cnt == 5'(cms_pkg::CMD_BITS);
  assign cmd = rx_sh[15:2];
  assign cmd_data = cmd[cms_pkg::CMD_DATA_LSB +: 8];
  assign cmd_addr = cmd[cms_pkg::CMD_ADDR_LSB +: 4];
  assign cmd_read = cmd[cms_pkg::CMD_RW_BIT];
  assign cmd_par_ok = ~^cmd;
  assign cmd_exit = !cmd_read && cmd_addr == cms_pkg::EXIT_ADDR && cmd_data == cms_pkg::EXIT_DATA;

  // start-up window counter; restarted on config exit without a reset
  always_ff @(posedge sys_clk) begin
    if (!rstn || (state == CMS_EXIT_TX && !tx_busy && !tx_go)) begin
      phase1_cnt <= 32'h0000_0000;
    end else if (state == CMS_PHASE1) begin
      phase1_cnt <= phase1_cnt + 32'h0000_0001;
    end
  end

  always_comb begin
    next_state = state;
    tx_start = 1'b0;
    next_frame = '0;
    do_store = 1'b0;
    unique case (state)
      CMS_PHASE1: begin
        if (key_ok) begin
          next_state = CMS_CFG_TX;
          tx_start = 1'b1;
          next_frame = build_frame(cms_pkg::THIRD_CONFIG_REGISTER_ADDR,
            cfg_value(cms_pkg::THIRD_CONFIG_REGISTER_ADDR, cfg_ram[cms_pkg::THIRD_CONFIG_REGISTER_ADDR], otp_lock_flag), cms_pkg::SV_OK);
        end else if (phase1_cnt >= 32'(PHASE1_CYCLES) - 32'h0000_0001) begin
          next_state = CMS_NORMAL;
        end
      end
      CMS_NORMAL: begin
        next_state = CMS_NORMAL;
      end
      CMS_CFG_IDLE: begin
        // commands arriving while an answer is still going out are dropped
        if (cmd_ok) begin
          tx_start = 1'b1;
          if (!cmd_par_ok) begin
            next_state = CMS_CFG_TX;
            next_frame = build_frame(4'h0, 8'h00, cms_pkg::SV_ERR);
          end else if (cmd_exit) begin
            next_state = CMS_EXIT_TX;
            next_frame = build_frame(cmd_addr, cmd_data, cms_pkg::SV_OK);
          end else if (cmd_read || otp_lock_flag) begin
            next_state = CMS_CFG_TX;
            next_frame = build_frame(cmd_addr,
              cfg_value(cmd_addr, cfg_ram[cmd_addr], otp_lock_flag), cms_pkg::SV_OK);
          end else begin
            next_state = CMS_CFG_TX;
            do_store = 1'b1;
            next_frame = build_frame(cmd_addr, cfg_value(cmd_addr, cmd_data, otp_lock_flag), cms_pkg::SV_OK);
          end
        end
      end
      CMS_CFG_TX: begin
        if (!tx_busy && !tx_go) begin
          next_state = CMS_CFG_IDLE;
        end
      end
      CMS_EXIT_TX: begin
        if (!tx_busy && !tx_go) begin
          next_state = CMS_PHASE1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= CMS_PHASE1;
    end else begin
      state <= next_state;
    end
  end

  // the word is latched first and the transmitter starts a cycle later, so it never loads a stale word
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tx_frame <= '0;
      tx_go <= 1'b0;
    end else begin
      tx_go <= tx_start;
      if (tx_start) begin
        tx_frame <= next_frame;
      end
    end
  end

  // configuration ram; writes are refused once the fuses are locked
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int i = 0; i < 16; i++) begin
        cfg_ram[i] <= 8'h00;
      end
    end else if (do_store) begin
      cfg_ram[cmd_addr] <= cmd_data;
    end
  end

  // sync pulses only outside config mode and only when synchronous mode is chosen
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sync_pulse <= 1'b0;
    end else begin
      sync_pulse <= state == CMS_NORMAL && ctrl_sync_mode && rx_rise;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      config_mode <= 1'b0;
      autozero_off <= 1'b0;
      sync_tx_disable <= 1'b0;
    end else begin
      config_mode <= next_state inside {CMS_CFG_IDLE, CMS_CFG_TX, CMS_EXIT_TX};
      autozero_off <= next_state inside {CMS_CFG_IDLE, CMS_CFG_TX, CMS_EXIT_TX};
      sync_tx_disable <= next_state != CMS_NORMAL;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bad_seen <= 1'b0;
    end else if (rx_bad) begin
      bad_seen <= 1'b1;
    end else if (avs_read && bus_ack && avs_address == cms_pkg::REG_STATUS) begin
      bad_seen <= 1'b0;
    end
  end

  // avalon slave: one wait cycle per access
  assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (avs_read || avs_write) && !bus_ack;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_sync_mode <= 1'b0;
      pulse_one <= cms_pkg::PULSE_ONE_RST;
      pulse_min <= cms_pkg::PULSE_MIN_RST;
      pulse_max <= cms_pkg::PULSE_MAX_RST;
    end else if (avs_write && bus_ack) begin
      // a write lands only at the edge that completes the access
      unique case (avs_address)
        cms_pkg::REG_CTRL: ctrl_sync_mode <= avs_writedata[cms_pkg::CTRL_SYNC_MODE];
        cms_pkg::REG_PULSE_ONE: pulse_one <= avs_writedata[7:0];
        cms_pkg::REG_PULSE_MIN: pulse_min <= avs_writedata[7:0];
        cms_pkg::REG_PULSE_MAX: pulse_max <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !bus_ack) begin
      avs_readdata <= 32'h0000_0000;
      if (avs_address >= cms_pkg::REG_CFG_BASE && avs_address < cms_pkg::REG_CFG_BASE + 8'h40) begin
        avs_readdata[7:0] <= cfg_value(avs_address[5:2], cfg_ram[avs_address[5:2]], otp_lock_flag);
      end else begin
        unique case (avs_address)
          cms_pkg::REG_CTRL: avs_readdata[cms_pkg::CTRL_SYNC_MODE] <= ctrl_sync_mode;
          cms_pkg::REG_PULSE_ONE: avs_readdata[7:0] <= pulse_one;
          cms_pkg::REG_PULSE_MIN: avs_readdata[7:0] <= pulse_min;
          cms_pkg::REG_PULSE_MAX: avs_readdata[7:0] <= pulse_max;
          cms_pkg::REG_STATUS: begin
            avs_readdata[cms_pkg::ST_PHASE1] <= state == CMS_PHASE1;
            avs_readdata[cms_pkg::ST_CONFIG] <= config_mode;
            avs_readdata[cms_pkg::ST_TX_BUSY] <= tx_busy;
            avs_readdata[cms_pkg::ST_LOCKED] <= otp_lock_flag;
            avs_readdata[cms_pkg::ST_BAD_PULSE] <= bad_seen;
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// ---- testbench/cms_config_port_checker.sv ----
`timescale 1ns/1ps
module cms_config_port_checker #(
  parameter int TX_HALF_CYCLES = 4,
  parameter int GAP_CYCLES = 80
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // link, fuse and modes
  input wire logic bus_supply_positive,
  input wire logic cur_tx_on,
  input wire logic otp_lock_flag,
  input wire logic config_mode,
  input wire logic autozero_off,
  input wire logic sync_tx_disable,
  input wire logic sync_pulse
);
  logic [9:0] hi_cnt;
  logic [9:0] lo_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // length of the current high run; manchester allows only one or two halves
  always_ff @(posedge sys_clk) begin
    if (!rstn || !cur_tx_on) begin
      hi_cnt <= 10'h0;
    end else if (hi_cnt != 10'h3FF) begin
      hi_cnt <= hi_cnt + 10'h1;
    end
  end
  // supply line idle time; a frame may only be judged after a full gap
  always_ff @(posedge sys_clk) begin
    if (!rstn || bus_supply_positive) begin
      lo_cnt <= 10'h0;
    end else if (lo_cnt != 10'h3FF) begin
      lo_cnt <= lo_cnt + 10'h1;
    end
  end
  sequence s_answer_start;
    ##[0:4] cur_tx_on;
  endsequence
  property p_cfg_quiet;
    config_mode |-> autozero_off && sync_tx_disable;
  endproperty
  property p_no_sync;
    sync_tx_disable |-> !sync_pulse;
  endproperty
  property p_entry_answer;
    $rose(config_mode) |-> s_answer_start;
  endproperty
  property p_entry_gap;
    $rose(config_mode) |-> lo_cnt >= GAP_CYCLES;
  endproperty
  property p_manch_run;
    $fell(cur_tx_on) |-> hi_cnt == TX_HALF_CYCLES || hi_cnt == 2 * TX_HALF_CYCLES;
  endproperty
  property p_tx_cfg;
    $rose(cur_tx_on) |-> ##[0:1] config_mode;
  endproperty
  property p_exit;
    $fell(config_mode) |-> sync_tx_disable && !autozero_off;
  endproperty
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet)
    else $error("autozero or sync transmit on in config mode");
  a_no_sync: assert property (p_no_sync)
    else $error("sync pulse outside normal mode");
  a_entry_answer: assert property (p_entry_answer)
    else $error("no answer on config entry");
  a_entry_gap: assert property (p_entry_gap)
    else $error("config entry before frame gap");
  a_manch_run: assert property (p_manch_run)
    else $error("bad manchester high run");
  a_tx_cfg: assert property (p_tx_cfg)
    else $error("transmit outside config mode");
  a_exit: assert property (p_exit)
    else $error("exit not back to start-up");
  a_one_wait: assert property (p_one_wait)
    else $error("wait state longer than one cycle");
endmodule

// ---- testbench/cms_tester_model.sv ----
`timescale 1ns/1ps
module cms_tester_model #(
  parameter int HALF = 4
) (
  // device clock, used to time pulses and sample answers
  input wire logic sys_clk,
  // device answer line
  input wire logic cur_tx_on,
  // supply-line pulses, high is a pulse
  output logic line
);
  int frames_seen = 0;
  logic [17:0] frame;
  logic manch_ok;
  logic h1;
  logic h2;
  initial line = 1'b0;
  // 160 ns per bit, 320 ns for the bad_at bit: long high is a one, short high a zero, bad_at stretches one pulse out of range
  task automatic send_bits(input logic [15:0] bits, input int n, input int bad_at);
    int hi;
    for (int i = 0; i < n; i++) begin
      hi = (i == bad_at) ? 28 : (bits[i] ? 24 : 8);
      @(posedge sys_clk);
      line <= 1'b1;
      repeat ((i == bad_at) ? 60 : hi) @(posedge sys_clk);
      line <= 1'b0;
      repeat (31 - hi) @(posedge sys_clk);
    end
  endtask
  // samples mid first and second half of every bit; a bit keeps its first-half level
  initial begin
    forever begin
      @(posedge sys_clk);
      if (cur_tx_on === 1'b1) begin
        manch_ok = 1'b1;
        for (int k = 0; k < 18; k++) begin
          repeat (HALF / 2) @(posedge sys_clk);
          h1 = cur_tx_on;
          repeat (HALF) @(posedge sys_clk);
          h2 = cur_tx_on;
          manch_ok = manch_ok & (h1 !== h2);
          frame[k] = h1;
          repeat (HALF - HALF / 2) @(posedge sys_clk);
        end
        frames_seen++;
      end
    end
  end
endmodule

// ---- testbench/cms_config_port_test.sv ----
`timescale 1ns/1ps
module cms_config_port_test;
  localparam int PHASE1 = 4000;
  localparam int HALF = 4;
  localparam int GAP = 80;
  logic sys_clk;
  logic rstn;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic bus_supply_positive;
  logic cur_tx_on;
  logic otp_lock_flag;
  logic config_mode;
  logic autozero_off;
  logic sync_tx_disable;
  logic sync_pulse;
  int fails = 0;
  int checks_done = 0;
  int sync_seen = 0;
  int n0;
  logic [31:0] rd;
  cms_config_port #(.PHASE1_CYCLES(PHASE1), .TX_HALF_CYCLES(HALF), .GAP_CYCLES(GAP)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bus_supply_positive(bus_supply_positive),
    .cur_tx_on(cur_tx_on), .otp_lock_flag(otp_lock_flag), .config_mode(config_mode),
    .autozero_off(autozero_off), .sync_tx_disable(sync_tx_disable), .sync_pulse(sync_pulse));
  cms_tester_model #(.HALF(HALF)) tester (.sys_clk(sys_clk), .cur_tx_on(cur_tx_on), .line(bus_supply_positive));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (sync_pulse === 1'b1) sync_seen <= sync_seen + 1;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    check("bus answer", n < 20, 1);
  endtask
  task automatic send_cmd(input logic rw, input logic [3:0] a, input logic [7:0] d, input logic bad, output int c);
    logic [13:0] f;
    f = {1'b0, rw, a, d};
    f[13] = ^f[12:0] ^ bad;
    c = tester.frames_seen;
    tester.send_bits({2'b00, f}, 14, -1);
  endtask
  task automatic expect_answer(input int c, input logic [3:0] a, input logic [7:0] d, input logic [2:0] sv);
    logic [15:0] w;
    int n;
    w = {1'b0, a, d, sv};
    w[15] = ^w[14:0];
    n = 0;
    while (tester.frames_seen == c && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    check("answer count", tester.frames_seen - c, 1);
    check("start bits", tester.frame[1:0], 2'b01);
    check("answer word", tester.frame[17:2], w);
    check("manchester", tester.manch_ok, 1);
  endtask
  task automatic t_reset_regs();
    logic [7:0] ad [6];
    logic [31:0] ex [6];
    ad = '{cms_pkg::REG_CTRL, cms_pkg::REG_PULSE_ONE, cms_pkg::REG_PULSE_MIN, cms_pkg::REG_PULSE_MAX,
      cms_pkg::REG_STATUS, 8'h20};
    ex = '{32'h0, cms_pkg::PULSE_ONE_RST, cms_pkg::PULSE_MIN_RST, cms_pkg::PULSE_MAX_RST, 32'h0000_0001, 32'h0};
    bus_xfer(1'b1, 8'h20, 32'hFFFF_FFFF, rd);
    for (int i = 0; i < 6; i++) begin
      bus_xfer(1'b0, ad[i], 32'h0, rd);
      check("reset register", rd, ex[i]);
    end
  endtask
  task automatic t_bad_frames();
    n0 = tester.frames_seen;
    tester.send_bits(cms_pkg::ENTRY_KEY, 16, 5);
    repeat (GAP + 40) @(posedge sys_clk);
    tester.send_bits(16'h1234, 14, -1);
    repeat (GAP + 200) @(posedge sys_clk);
    check("ignored frames", tester.frames_seen - n0, 0);
    check("still start-up", config_mode, 0);
    bus_xfer(1'b0, cms_pkg::REG_STATUS, 32'h0, rd);
    check("bad pulse flag", rd, 32'h0000_0011);
  endtask
  task automatic t_key_entry();
    n0 = tester.frames_seen;
    tester.send_bits(cms_pkg::ENTRY_KEY, 16, -1);
    expect_answer(n0, cms_pkg::THIRD_CONFIG_REGISTER_ADDR, 8'h00, cms_pkg::SV_OK);
    check("modes", {config_mode, autozero_off, sync_tx_disable}, 3'h7);
  endtask
  task automatic t_commands();
    send_cmd(1'b0, 4'h3, 8'hA5, 1'b0, n0);
    expect_answer(n0, 4'h3, 8'hA5, cms_pkg::SV_OK);
    send_cmd(1'b1, 4'h3, 8'h5C, 1'b0, n0);
    expect_answer(n0, 4'h3, 8'hA5, cms_pkg::SV_OK);
    bus_xfer(1'b1, cms_pkg::REG_CFG_BASE + 8'h0C, 32'h0000_00FF, rd);
    bus_xfer(1'b0, cms_pkg::REG_CFG_BASE + 8'h0C, 32'h0, rd);
    check("config reg 3", rd, 32'h0000_00A5);
    send_cmd(1'b0, 4'h4, 8'h11, 1'b1, n0);
    expect_answer(n0, 4'h0, 8'h00, cms_pkg::SV_ERR);
    otp_lock_flag <= 1'b1;
    send_cmd(1'b0, 4'h3, 8'h3C, 1'b0, n0);
    expect_answer(n0, 4'h3, 8'hA5, cms_pkg::SV_OK);
    send_cmd(1'b1, cms_pkg::THIRD_CONFIG_REGISTER_ADDR, 8'h00, 1'b0, n0);
    expect_answer(n0, cms_pkg::THIRD_CONFIG_REGISTER_ADDR, 8'h01, cms_pkg::SV_OK);
    otp_lock_flag <= 1'b0;
  endtask
  task automatic t_exit_and_normal();
    int s0;
    send_cmd(1'b0, cms_pkg::EXIT_ADDR, cms_pkg::EXIT_DATA, 1'b0, n0);
    expect_answer(n0, cms_pkg::EXIT_ADDR, cms_pkg::EXIT_DATA, cms_pkg::SV_OK);
    bus_xfer(1'b0, cms_pkg::REG_STATUS, 32'h0, rd);
    check("restarted start-up", rd, 32'h0000_0001);
    repeat (PHASE1 + 20) @(posedge sys_clk);
    check("normal mode", sync_tx_disable, 0);
    s0 = sync_seen;
    n0 = tester.frames_seen;
    tester.send_bits(cms_pkg::ENTRY_KEY, 16, -1);
    repeat (GAP + 200) @(posedge sys_clk);
    check("late key", {config_mode, 31'(tester.frames_seen - n0)}, 32'h0);
    check("async pulses", sync_seen - s0, 0);
    bus_xfer(1'b1, cms_pkg::REG_CTRL, 32'h0000_0001, rd);
    s0 = sync_seen;
    tester.send_bits(16'h0005, 3, -1);
    repeat (20) @(posedge sys_clk);
    check("sync pulses", sync_seen - s0, 3);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge sys_clk);
    fails++;
    final_report();
  end
  initial begin
    rstn = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    otp_lock_flag = 1'b0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset_regs();
    t_bad_frames();
    t_key_entry();
    t_commands();
    t_exit_and_normal();
    final_report();
  end
endmodule
bind cms_config_port cms_config_port_checker #(.TX_HALF_CYCLES(TX_HALF_CYCLES), .GAP_CYCLES(GAP_CYCLES)) chk (
  .sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .bus_supply_positive(bus_supply_positive),
  .cur_tx_on(cur_tx_on), .otp_lock_flag(otp_lock_flag), .config_mode(config_mode),
  .autozero_off(autozero_off), .sync_tx_disable(sync_tx_disable), .sync_pulse(sync_pulse));
